/* inc/speed_mode_pkg.sv */
package speed_mode_pkg;

  // ----------------------------------------------------------------
  // Program-executing and halted power modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_HIGH,
    MODE_MEDIUM,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_WATCH,
    MODE_STANDBY,
    MODE_SUBSLEEP
  } power_mode_e;

  // ----------------------------------------------------------------
  // Clock ratios and state counts
  // ----------------------------------------------------------------
  localparam int MEDIUM_DIVIDE = 8;
  localparam int SLEEP_INSN_STATES = 2;
  localparam int INTERNAL_STATES = 1;
  localparam int EXCEPTION_STATES = 14;
  localparam int SUB_DIVIDE_DEFAULT = 8;
  localparam int WAIT_WIDTH = 18;
  localparam logic [17:0] WAIT_STATES_0 = 18'h02000;
  localparam logic [17:0] WAIT_STATES_1 = 18'h04000;
  localparam logic [17:0] WAIT_STATES_2 = 18'h08000;
  localparam logic [17:0] WAIT_STATES_3 = 18'h10000;
  localparam logic [17:0] WAIT_STATES_4 = 18'h20000;
  localparam int SETTLE_SEL_TOP = 2;

endpackage : speed_mode_pkg

/* hdl/state_pacer.sv */
// Emits one state tick every DIVIDE clocks while running; restarts on clear.
module state_pacer #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic clear,
  input wire logic [WIDTH-1:0] divide,
  // Tick out.
  output logic tick
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // Count up to the end of one state; a divide of zero acts as one.
  always_comb begin
    count_nxt = count_r + 1'b1;
    tick = (count_r + 1'b1 >= divide);
    if (clear || tick) begin
      count_nxt = '0;
    end
  end

  // Counter register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : state_pacer

/* hdl/settle_decode.sv */
// Maps the three-bit settling wait field onto a state count.
module settle_decode (
  // Field in.
  input wire logic [2:0] settlingWaitSelect,
  // Count out.
  output logic [speed_mode_pkg::WAIT_WIDTH-1:0] waitStates
);

  // Any code with the top bit set selects the longest wait.
  always_comb begin
    if (settlingWaitSelect[speed_mode_pkg::SETTLE_SEL_TOP]) begin
      waitStates = speed_mode_pkg::WAIT_STATES_4;
    end else begin
      case (settlingWaitSelect[1:0])
        2'h0: waitStates = speed_mode_pkg::WAIT_STATES_0;
        2'h1: waitStates = speed_mode_pkg::WAIT_STATES_1;
        2'h2: waitStates = speed_mode_pkg::WAIT_STATES_2;
        default: waitStates = speed_mode_pkg::WAIT_STATES_3;
      endcase
    end
  end

endmodule : settle_decode

/* hdl/direct_speed_mode_transfer.sv */
// How it works
// - Sleep with direct-transfer enable switches among running speed modes without halting.
// - After the direct change completes, direct-transfer interrupt exception handling starts.
// - Direct-transfer interrupt disabled: enter sleep or watch mode instead.
// - Global mask set: enter sleep or watch, and no interrupt releases it.
// - High-speed, selects 0/0/medium 1, enable 1: go medium via sleep.
// - Medium-speed, selects 0/0/medium 0, enable 1: go high via sleep.
// - High-speed, standby 1, low 1, enable 1, watch 1: go subactive via watch.
// - Medium-speed, same settings as go subactive via watch.
// - Subactive, standby 1, low 0, medium 0, watch 1: high after settling.
// - Subactive, standby 1, low 0, medium 1, watch 1: medium after settling.
// - Active to active: sleep plus internal on old clock, 14 states on new.
// - From subactive: sleep states on subclock, then wait plus 14 on new clock.
// - Medium-speed mode clocks the CPU at one eighth of high-speed.
// - Settling field selects 8192 to 65536 states, top bit set gives 131072.
module direct_speed_mode_transfer #(
  parameter int SUB_DIVIDE = speed_mode_pkg::SUB_DIVIDE_DEFAULT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // CPU side.
  input wire logic sleepExec,
  input wire logic exceptionDone,
  input wire logic wakeRequest,
  // Control bits.
  input wire logic directTransferEnable,
  input wire logic standbySelect,
  input wire logic lowSpeedSelect,
  input wire logic mediumSpeedSelect,
  input wire logic watchTimerSelect,
  input wire logic directIrqEnable,
  input wire logic globalIrqMask,
  input wire logic [2:0] settlingWaitSelect,
  // Status.
  output speed_mode_pkg::power_mode_e powerMode,
  output logic cpuRunning,
  output logic directIrqRequest,
  output logic [3:0] cpuClockDivide,
  output logic transferBusy
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_OLD_CLOCK,
    SEQ_SETTLE,
    SEQ_EXCEPTION,
    SEQ_HALTED
  } seq_e;

  seq_e seq_r;
  seq_e seq_nxt;
  speed_mode_pkg::power_mode_e mode_r;
  speed_mode_pkg::power_mode_e mode_nxt;
  speed_mode_pkg::power_mode_e target_r;
  speed_mode_pkg::power_mode_e target_nxt;
  logic [17:0] states_r;
  logic [17:0] states_nxt;
  logic [3:0] divide_r;
  logic [3:0] divide_nxt;
  logic irq_r;
  logic irq_nxt;
  logic locked_r;
  logic locked_nxt;
  // Remembers a start from subactive mode once mode_r has moved on to watch mode.
  logic fromSub_r;
  logic fromSub_nxt;
  logic tick;
  logic [17:0] waitStates;
  logic [3:0] pacerDivide;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  settle_decode u_settle (
    .settlingWaitSelect(settlingWaitSelect),
    .waitStates(waitStates)
  );

  // The pacer runs at the divide for the mode now clocking the CPU.
  assign pacerDivide = divide_r;

  state_pacer #(.WIDTH(4)) u_pacer (
    .clk(clk),
    .reset_n(reset_n),
    .clear(seq_r != seq_nxt),
    .divide(pacerDivide),
    .tick(tick)
  );

  function automatic logic [3:0] divide_for(speed_mode_pkg::power_mode_e m);
    if (m == speed_mode_pkg::MODE_MEDIUM) begin
      return 4'(speed_mode_pkg::MEDIUM_DIVIDE);
    end else if (m == speed_mode_pkg::MODE_SUBACTIVE) begin
      return 4'(SUB_DIVIDE);
    end
    return 4'h1;
  endfunction : divide_for

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic active;
    logic sub;
    active = (mode_r == speed_mode_pkg::MODE_HIGH) || (mode_r == speed_mode_pkg::MODE_MEDIUM);
    sub = (mode_r == speed_mode_pkg::MODE_SUBACTIVE);
    seq_nxt = seq_r;
    mode_nxt = mode_r;
    target_nxt = target_r;
    states_nxt = states_r;
    divide_nxt = divide_r;
    irq_nxt = irq_r;
    locked_nxt = locked_r;
    fromSub_nxt = fromSub_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (sleepExec && directTransferEnable) begin
          target_nxt = mode_r;
          if (active && !standbySelect && !lowSpeedSelect) begin
            target_nxt = mediumSpeedSelect ? speed_mode_pkg::MODE_MEDIUM
                                           : speed_mode_pkg::MODE_HIGH;
          end else if (active && standbySelect && lowSpeedSelect && watchTimerSelect) begin
            target_nxt = speed_mode_pkg::MODE_SUBACTIVE;
          end else if (sub && standbySelect && !lowSpeedSelect && watchTimerSelect) begin
            target_nxt = mediumSpeedSelect ? speed_mode_pkg::MODE_MEDIUM
                                           : speed_mode_pkg::MODE_HIGH;
          end
          if (target_nxt != mode_r && directIrqEnable && !globalIrqMask) begin
            states_nxt = 18'(speed_mode_pkg::SLEEP_INSN_STATES
                             + speed_mode_pkg::INTERNAL_STATES);
            seq_nxt = SEQ_OLD_CLOCK;
            fromSub_nxt = sub;
          end else begin
            // Halted entry chosen by the plain sleep decode.
            if (standbySelect && watchTimerSelect) begin
              mode_nxt = speed_mode_pkg::MODE_WATCH;
            end else if (standbySelect && !lowSpeedSelect && active) begin
              mode_nxt = speed_mode_pkg::MODE_STANDBY;
            end else if (!standbySelect && lowSpeedSelect && watchTimerSelect && sub) begin
              mode_nxt = speed_mode_pkg::MODE_SUBSLEEP;
            end else begin
              mode_nxt = speed_mode_pkg::MODE_SLEEP;
            end
            target_nxt = mode_r;
            locked_nxt = globalIrqMask;
            seq_nxt = SEQ_HALTED;
          end
        end
      end
      SEQ_OLD_CLOCK: begin
        // Remaining sleep states still run on the clock of the old mode. mode_r shows the halted mode
        // from the second cycle here, so where the transfer began is read from fromSub_r instead.
        mode_nxt = (target_r == speed_mode_pkg::MODE_SUBACTIVE || fromSub_r)
                   ? speed_mode_pkg::MODE_WATCH : speed_mode_pkg::MODE_SLEEP;
        if (tick) begin
          states_nxt = states_r - 18'h00001;
          if (states_r == 18'h00001) begin
            divide_nxt = divide_for(target_r);
            if (fromSub_r) begin
              states_nxt = waitStates;
              seq_nxt = SEQ_SETTLE;
            end else begin
              states_nxt = 18'(speed_mode_pkg::EXCEPTION_STATES);
              mode_nxt = target_r;
              irq_nxt = 1'b1;
              seq_nxt = SEQ_EXCEPTION;
            end
          end
        end
      end
      SEQ_SETTLE: begin
        // Oscillator settling is counted on the new system clock.
        if (tick) begin
          states_nxt = states_r - 18'h00001;
          if (states_r == 18'h00001) begin
            states_nxt = 18'(speed_mode_pkg::EXCEPTION_STATES);
            mode_nxt = target_r;
            irq_nxt = 1'b1;
            seq_nxt = SEQ_EXCEPTION;
          end
        end
      end
      SEQ_EXCEPTION: begin
        // Request holds until the CPU has spent its exception states and acknowledged.
        if (tick && states_r != 18'h00000) begin
          states_nxt = states_r - 18'h00001;
        end
        if (exceptionDone && states_r == 18'h00000) begin
          irq_nxt = 1'b0;
          seq_nxt = SEQ_IDLE;
        end
      end
      SEQ_HALTED: begin
        // A masked entry can only be left by reset.
        if (wakeRequest && !locked_r) begin
          mode_nxt = target_r;
          seq_nxt = SEQ_IDLE;
        end
      end
      default: begin
        seq_nxt = SEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= SEQ_IDLE;
      mode_r <= speed_mode_pkg::MODE_HIGH;
      target_r <= speed_mode_pkg::MODE_HIGH;
      states_r <= 18'h00000;
      divide_r <= 4'h1;
      irq_r <= 1'b0;
      locked_r <= 1'b0;
      fromSub_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      mode_r <= mode_nxt;
      target_r <= target_nxt;
      states_r <= states_nxt;
      divide_r <= divide_nxt;
      irq_r <= irq_nxt;
      locked_r <= locked_nxt;
      fromSub_r <= fromSub_nxt;
    end
  end

  // Outputs come from registers; transferBusy and cpuRunning are decoded from seq_r and mode_r.
  assign powerMode = mode_r;
  assign directIrqRequest = irq_r;
  assign cpuClockDivide = divide_r;
  assign transferBusy = (seq_r != SEQ_IDLE) && (seq_r != SEQ_HALTED);
  assign cpuRunning = (mode_r == speed_mode_pkg::MODE_HIGH)
                   || (mode_r == speed_mode_pkg::MODE_MEDIUM)
                   || (mode_r == speed_mode_pkg::MODE_SUBACTIVE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MASK_LOCKS: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_IDLE && sleepExec && directTransferEnable && globalIrqMask)
    |=> (seq_r == SEQ_HALTED && locked_r))
    else $error("masked direct transfer did not lock halted mode");
  AST_DISABLED_HALTS: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_IDLE && sleepExec && directTransferEnable && !directIrqEnable)
    |=> !cpuRunning && !irq_r)
    else $error("disabled direct transfer kept running");
  AST_HIGH_TO_MED: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_IDLE && mode_r == speed_mode_pkg::MODE_HIGH && sleepExec
     && directTransferEnable && !standbySelect && !lowSpeedSelect && mediumSpeedSelect
     && directIrqEnable && !globalIrqMask)
    |=> ##[1:4] (mode_r == speed_mode_pkg::MODE_MEDIUM && irq_r))
    else $error("high to medium direct transfer late");
  // Three old-clock states at a divide of eight end on the 24th edge after the take.
  AST_MED_TO_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_IDLE && mode_r == speed_mode_pkg::MODE_MEDIUM && sleepExec
     && directTransferEnable && !standbySelect && !lowSpeedSelect && !mediumSpeedSelect
     && directIrqEnable && !globalIrqMask)
    |=> ##[22:26] (mode_r == speed_mode_pkg::MODE_HIGH && irq_r))
    else $error("medium to high direct transfer not on time");
  AST_TO_SUB: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_IDLE && (mode_r == speed_mode_pkg::MODE_HIGH
     || mode_r == speed_mode_pkg::MODE_MEDIUM) && sleepExec && directTransferEnable
     && standbySelect && lowSpeedSelect && watchTimerSelect
     && directIrqEnable && !globalIrqMask)
    |=> seq_r == SEQ_OLD_CLOCK ##1 mode_r == speed_mode_pkg::MODE_WATCH)
    else $error("active to subactive did not pass through watch mode");
  AST_SUB_SETTLES: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_OLD_CLOCK && fromSub_r)
    |=> (seq_r != SEQ_EXCEPTION && mode_r == speed_mode_pkg::MODE_WATCH))
    else $error("subactive exit skipped the settling wait");
  AST_OLD_DIVIDE: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_OLD_CLOCK) |-> $stable(divide_r))
    else $error("clock divide changed during the old-clock states");
  AST_MED_DIVIDE: assert property (@(posedge clk) disable iff (!reset_n)
    (mode_r == speed_mode_pkg::MODE_MEDIUM && seq_r == SEQ_EXCEPTION)
    |-> divide_r == 4'h8)
    else $error("medium mode divide wrong");
  AST_IRQ_RISE: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(irq_r) |-> seq_r == SEQ_EXCEPTION && cpuRunning
                     && states_r == 18'(speed_mode_pkg::EXCEPTION_STATES))
    else $error("direct interrupt raised out of place");
  AST_IRQ_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_r && !exceptionDone) |=> irq_r)
    else $error("direct interrupt dropped before the handler finished");
  AST_SETTLE_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(seq_r == SEQ_SETTLE) |-> states_r == $past(waitStates))
    else $error("settling wait not loaded");
  AST_LOCKED_STAYS: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_HALTED && locked_r) |=> seq_r == SEQ_HALTED)
    else $error("locked halt released");
  AST_SUB_WATCH: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_r == SEQ_SETTLE) |-> mode_r == speed_mode_pkg::MODE_WATCH)
    else $error("settling not in watch mode");

endmodule : direct_speed_mode_transfer

/* bench/cpu_model.sv */
module cpu_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Device side.
  input wire logic directIrqRequest,
  input wire logic [3:0] cpuClockDivide,
  // Handler finished.
  output logic exceptionDone
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // -----------------------------------------------------------
  // Exception handler
  // -----------------------------------------------------------
  // The handler runs on the new clock, so it paces itself by the current divide.
  // A one-cycle acknowledge avoids re-acking an irq that is still dropping.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt = 0;
      exceptionDone <= 1'b0;
    end else if (directIrqRequest && !exceptionDone) begin
      cnt = cnt + 1;
      if (cnt >= 14 * cpuClockDivide) begin
        exceptionDone <= 1'b1;
      end
    end else begin
      cnt = 0;
      exceptionDone <= 1'b0;
    end
  end
endmodule : cpu_model

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short names for the power modes, bound to the package's values.
  localparam speed_mode_pkg::power_mode_e MODE_HIGH = speed_mode_pkg::MODE_HIGH;
  localparam speed_mode_pkg::power_mode_e MODE_MEDIUM = speed_mode_pkg::MODE_MEDIUM;
  localparam speed_mode_pkg::power_mode_e MODE_SUBACTIVE = speed_mode_pkg::MODE_SUBACTIVE;
  localparam speed_mode_pkg::power_mode_e MODE_SLEEP = speed_mode_pkg::MODE_SLEEP;
  localparam speed_mode_pkg::power_mode_e MODE_WATCH = speed_mode_pkg::MODE_WATCH;
  localparam speed_mode_pkg::power_mode_e MODE_STANDBY = speed_mode_pkg::MODE_STANDBY;
  localparam int SUB_DIV = 4;
  logic clk, reset_n, sleepExec, exceptionDone, wakeRequest;
  logic directTransferEnable, directIrqEnable, globalIrqMask;
  logic standbySelect, lowSpeedSelect, mediumSpeedSelect, watchTimerSelect;
  logic [2:0] settlingWaitSelect;
  speed_mode_pkg::power_mode_e powerMode;
  logic cpuRunning, directIrqRequest, transferBusy;
  logic [3:0] cpuClockDivide;
  int miscompares = 0;
  int comparisons = 0;

  direct_speed_mode_transfer #(.SUB_DIVIDE(SUB_DIV)) u_direct_speed_mode_transfer (
    .clk(clk), .reset_n(reset_n), .sleepExec(sleepExec), .exceptionDone(exceptionDone),
    .wakeRequest(wakeRequest), .directTransferEnable(directTransferEnable),
    .standbySelect(standbySelect), .lowSpeedSelect(lowSpeedSelect),
    .mediumSpeedSelect(mediumSpeedSelect), .watchTimerSelect(watchTimerSelect),
    .directIrqEnable(directIrqEnable), .globalIrqMask(globalIrqMask),
    .settlingWaitSelect(settlingWaitSelect), .powerMode(powerMode), .cpuRunning(cpuRunning),
    .directIrqRequest(directIrqRequest), .cpuClockDivide(cpuClockDivide),
    .transferBusy(transferBusy));
  cpu_model u_cpu_model (.clk(clk), .reset_n(reset_n), .directIrqRequest(directIrqRequest),
    .cpuClockDivide(cpuClockDivide), .exceptionDone(exceptionDone));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t ns: %s", $time, msg);
    end
  endtask : check

  task automatic close_out();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic tick();
    @(posedge clk);
    #10;
  endtask : tick

  // Bits are {standby, low speed, medium speed, watch timer}; sleep lasts one clock.
  task automatic sleep_with(input logic [3:0] bits);
    {standbySelect, lowSpeedSelect, mediumSpeedSelect, watchTimerSelect} = bits;
    sleepExec = 1'b1;
    tick();
    sleepExec = 1'b0;
  endtask : sleep_with

  // Times a direct transfer from the sleep edge to the irq; timing is only
  // judged where the timed flag is set, on every leg but the two into subactive.
  task automatic direct(input logic [3:0] bits, input speed_mode_pkg::power_mode_e target,
                        input int oldDiv, input int newDiv, input int waitSt, input bit timed);
    int n;
    int lo;
    int ex;
    bit via;
    n = 0;
    via = 0;
    lo = 3 * oldDiv + waitSt * newDiv;
    ex = speed_mode_pkg::EXCEPTION_STATES * newDiv;
    sleep_with(bits);
    while (directIrqRequest !== 1'b1 && n < 70000) begin
      via |= (powerMode === MODE_SLEEP || powerMode === MODE_WATCH);
      tick();
      n++;
    end
    check(via && powerMode === target && cpuClockDivide === 4'(newDiv), "target mode");
    check(cpuRunning === 1'b1 && transferBusy === 1'b1, "running after transfer");
    if (timed) begin
      check(n >= lo && n <= lo + 2 * oldDiv + 2 * newDiv + 2, "transfer time");
    end
    n = 0;
    while (transferBusy !== 1'b0 && n < ex + 20) begin
      tick();
      n++;
    end
    check(directIrqRequest === 1'b0 && transferBusy === 1'b0, "irq cleared by handler");
    check(n >= ex && n <= ex + 2, "exception states on new clock");
    $display("Test done: transfer to %s", target.name());
  endtask : direct

  // Holds a wake interrupt until the CPU runs again, with a bound.
  task automatic wake(input int bound);
    int n;
    n = 0;
    wakeRequest = 1'b1;
    while (cpuRunning !== 1'b1 && n < bound) begin
      tick();
      n++;
    end
    wakeRequest = 1'b0;
    tick();
  endtask : wake

  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {sleepExec, wakeRequest, globalIrqMask} = 3'h0;
    {standbySelect, lowSpeedSelect, mediumSpeedSelect, watchTimerSelect} = 4'h0;
    {directTransferEnable, directIrqEnable} = 2'h3;
    settlingWaitSelect = 3'h0;
    repeat (4) @(posedge clk);
    #10;
    reset_n = 1'b1;
    tick();
    check(powerMode === MODE_HIGH && cpuClockDivide === 4'h1 && cpuRunning === 1'b1, "reset");
    direct(4'h2, MODE_MEDIUM, 1, 8, 0, 1);
    direct(4'h0, MODE_HIGH, 8, 1, 0, 1);
    direct(4'hd, MODE_SUBACTIVE, 1, SUB_DIV, 0, 0);
    settlingWaitSelect = 3'h1;
    direct(4'h9, MODE_HIGH, SUB_DIV, 1, 16384, 1);
    settlingWaitSelect = 3'h0;
    direct(4'h2, MODE_MEDIUM, 1, 8, 0, 1);
    direct(4'hd, MODE_SUBACTIVE, 8, SUB_DIV, 0, 0);
    direct(4'hb, MODE_MEDIUM, SUB_DIV, 8, 8192, 1);
    direct(4'h0, MODE_HIGH, 8, 1, 0, 1);
    directIrqEnable = 1'b0;
    sleep_with(4'h2);
    tick();
    check(powerMode === MODE_SLEEP && cpuRunning === 1'b0, "disabled irq halts");
    wake(100);
    check(powerMode === MODE_HIGH && directIrqRequest === 1'b0, "wake to high");
    $display("Test done: disabled direct irq");
    directIrqEnable = 1'b1;
    sleep_with(4'h8);
    tick();
    check(powerMode === MODE_STANDBY && cpuRunning === 1'b0, "plain standby");
    wake(9000);
    check(powerMode === MODE_HIGH, "standby exit");
    $display("Test done: no direct path");
    globalIrqMask = 1'b1;
    sleep_with(4'h2);
    wakeRequest = 1'b1;
    repeat (20) tick();
    check(powerMode === MODE_SLEEP && cpuRunning === 1'b0, "mask locks sleep");
    wakeRequest = 1'b0;
    reset_n = 1'b0;
    tick();
    reset_n = 1'b1;
    tick();
    check(powerMode === MODE_HIGH && cpuRunning === 1'b1, "reset clears lock");
    $display("Test done: masked attempt");
    close_out();
  end

  initial begin
    #10_000_000;
    miscompares++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    close_out();
  end
endmodule : tb_top
